// ---- verilog/ufc_pkg.sv ----
// constants shared by the serial channel files
package ufc_pkg;
    // register indexes; byte address is index times four
    localparam logic [3:0] IDX_DATA   = 4'h0;
    localparam logic [3:0] IDX_IER    = 4'h1;
    localparam logic [3:0] IDX_ISR    = 4'h2;
    localparam logic [3:0] IDX_LFC    = 4'h3;
    localparam logic [3:0] IDX_MCR    = 4'h4;
    localparam logic [3:0] IDX_LSR    = 4'h5;
    localparam logic [3:0] IDX_AUX    = 4'h6;
    localparam logic [3:0] IDX_KEY    = 4'h7;
    localparam logic [3:0] IDX_EV_ST  = 4'h8;
    localparam logic [3:0] IDX_EV_CLR = 4'h9;
    localparam logic [3:0] IDX_EV_EN  = 4'ha;
    // extended page aliases
    localparam logic [3:0] IDX_TTR    = 4'h4;
    localparam logic [3:0] IDX_RTR    = 4'h5;
    localparam logic [3:0] IDX_AFR    = 4'h6;
    // keys and field positions
    localparam int         LFC_DIV_BIT = 7;
    localparam logic [7:0] LFC_EXT     = 8'hbf;
    localparam logic [7:0] KEY_OPEN    = 8'ha5;
    localparam logic [7:0] KEY_CLOSE   = 8'ha4;
    localparam int         AFR_BIG_BIT = 0;
    localparam int         MCR_CNT_BIT = 6;
    localparam int         IER_RX_BIT  = 0;
    localparam int         IER_TX_BIT  = 1;
    localparam logic [5:0] ISR_ID_RX   = 6'h04;
    localparam logic [5:0] ISR_ID_TX   = 6'h02;
    localparam logic [5:0] ISR_ID_NONE = 6'h01;
    // reset values
    localparam logic [7:0]  LFC_RST = 8'h00;
    localparam logic [7:0]  IER_RST = 8'h00;
    localparam logic [7:0]  MCR_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [7:0]  TTR_RST = 8'h08;
    localparam logic [7:0]  RTR_RST = 8'h08;
    localparam logic [7:0]  AFR_RST = 8'h00;
    localparam logic [7:0]  KEY_RST = 8'h00;
    // fifo depths and bit timing
    localparam int         DEPTH_BIG   = 256;
    localparam int         DEPTH_SMALL = 64;
    localparam logic [3:0] OVS_LAST    = 4'hf;
    localparam logic [3:0] OVS_MID     = 4'h7;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ufc_bit_t;
endpackage

// ---- verilog/ufc_fifo_mem.sv ----
// byte store for one channel fifo, registered read port
`timescale 1ns/100ps
module ufc_fifo_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // clock
    input  wire  logic          aclk,
    // write side
    input  wire  logic          wr_en,
    input  wire  logic [AW-1:0] wr_addr,
    input  wire  logic [W-1:0]  wr_data,
    // read side
    input  wire  logic [AW-1:0] rd_addr,
    output logic       [W-1:0]  rd_data
);
    logic [W-1:0] mem_q [DEPTH];

    // no reset on purpose: storage only, validity lives in the pointers
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule

// ---- verilog/ufc_serial.sv ----
// serial shifter: one transmitter and one receiver, 16x oversampled
`timescale 1ns/100ps
module ufc_serial import ufc_pkg::*; (
    // clock and reset
    input  wire  logic       aclk,
    input  wire  logic       aresetn,
    input  wire  logic       tick,
    // frame format
    input  wire  logic [1:0] dbits,
    input  wire  logic       two_stop,
    input  wire  logic       par_en,
    input  wire  logic       par_even,
    // transmit byte stream
    input  wire  logic       tx_valid,
    input  wire  logic [7:0] tx_byte,
    output logic             tx_take,
    output logic             tx_idle,
    // receive byte stream
    output logic             rx_stb,
    output logic       [7:0] rx_byte,
    output logic             rx_err,
    // pins
    output logic             txd,
    input  wire  logic       rxd
);
    ufc_bit_t   ts_q, ts_d, rs_q, rs_d;
    logic [3:0] tph_q, tph_d, rph_q, rph_d;
    logic [2:0] tbit_q, tbit_d, rbit_q, rbit_d, last;
    logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d, mask;
    logic       tpar_q, tpar_d, txd_q, txd_d, rbad_q, rbad_d, rpar_q, rpar_d;
    logic       rs1_q, rs2_q;

    assign last    = 3'd4 + {1'b0, dbits};
    assign mask    = 8'hff >> (2'd3 - dbits);
    assign txd     = txd_q;
    assign tx_idle = (ts_q == S_IDLE);
    assign rx_byte = rsh_q >> (2'd3 - dbits);

    always_comb begin
        ts_d = ts_q; tph_d = tph_q; tbit_d = tbit_q;
        tsh_d = tsh_q; tpar_d = tpar_q; txd_d = txd_q; tx_take = 1'b0;
        case (ts_q)
            S_IDLE: begin
                txd_d = 1'b1;
                if (tx_valid) begin
                    tx_take = 1'b1;
                    tsh_d   = tx_byte;
                    tpar_d  = (^(tx_byte & mask)) ^ ~par_even;
                    ts_d    = S_START;
                    tph_d   = 4'h0;
                    txd_d   = 1'b0;
                end
            end
            default: begin
                if (tick) begin
                    tph_d = tph_q + 4'h1;
                    if (tph_q == OVS_LAST) begin
                        case (ts_q)
                            S_START: begin
                                ts_d = S_DATA; tbit_d = 3'd0; txd_d = tsh_q[0];
                            end
                            S_DATA: begin
                                if (tbit_q == last) begin
                                    ts_d  = par_en ? S_PAR : S_STOP;
                                    txd_d = par_en ? tpar_q : 1'b1;
                                    tbit_d = 3'd0;
                                end else begin
                                    tsh_d  = tsh_q >> 1;
                                    txd_d  = tsh_q[1];
                                    tbit_d = tbit_q + 3'd1;
                                end
                            end
                            S_PAR: begin
                                ts_d = S_STOP; txd_d = 1'b1; tbit_d = 3'd0;
                            end
                            default: begin
                                // second stop bit reuses the bit counter
                                if (two_stop && tbit_q == 3'd0) tbit_d = 3'd1;
                                else ts_d = S_IDLE;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    always_comb begin
        rs_d = rs_q; rph_d = rph_q; rbit_d = rbit_q; rsh_d = rsh_q;
        rpar_d = rpar_q; rbad_d = rbad_q; rx_stb = 1'b0; rx_err = 1'b0;
        case (rs_q)
            S_IDLE: begin
                if (!rs2_q) begin
                    rs_d = S_START; rph_d = 4'h0; rpar_d = 1'b0;
                end
            end
            S_START: begin
                // half a bit later, a high line means a glitch, not a start
                if (tick) begin
                    rph_d = rph_q + 4'h1;
                    if (rph_q == OVS_MID) begin
                        rs_d   = rs2_q ? S_IDLE : S_DATA;
                        rph_d  = 4'h0;
                        rbit_d = 3'd0;
                        rpar_d = ~par_even;
                    end
                end
            end
            default: begin
                if (tick) begin
                    rph_d = rph_q + 4'h1;
                    if (rph_q == OVS_LAST) begin
                        case (rs_q)
                            S_DATA: begin
                                rsh_d  = {rs2_q, rsh_q[7:1]};
                                rpar_d = rpar_q ^ rs2_q;
                                rbit_d = rbit_q + 3'd1;
                                if (rbit_q == last) rs_d = par_en ? S_PAR : S_STOP;
                            end
                            S_PAR: begin
                                rbad_d = rpar_q ^ rs2_q;
                                rs_d   = S_STOP;
                            end
                            default: begin
                                rx_stb = 1'b1;
                                rx_err = !rs2_q || (par_en && rbad_q);
                                rbad_d = 1'b0;
                                rs_d   = S_IDLE;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ts_q <= S_IDLE; tph_q <= 4'h0; tbit_q <= 3'd0; tsh_q <= 8'h00;
            tpar_q <= 1'b0; txd_q <= 1'b1;
            rs_q <= S_IDLE; rph_q <= 4'h0; rbit_q <= 3'd0; rsh_q <= 8'h00;
            rpar_q <= 1'b0; rbad_q <= 1'b0; rs1_q <= 1'b1; rs2_q <= 1'b1;
        end else begin
            ts_q <= ts_d; tph_q <= tph_d; tbit_q <= tbit_d; tsh_q <= tsh_d;
            tpar_q <= tpar_d; txd_q <= txd_d;
            rs_q <= rs_d; rph_q <= rph_d; rbit_q <= rbit_d; rsh_q <= rsh_d;
            rpar_q <= rpar_d; rbad_q <= rbad_d; rs1_q <= rxd; rs2_q <= rs1_q;
        end
    end
endmodule

// ---- verilog/ufc_channel.sv ----
// one serial channel with fifos, paged registers and an AXI4-Lite slave
// Summary of operation
// RULE1: line format 80h maps divisor low and high bytes at data and enable slots.
// RULE2: host saves line format before divisor access and restores it afterwards.
// RULE3: trigger levels and extra feature writable only with format BFh and key A5h.
// RULE4: extra feature bit 0 set switches both fifos to 256-byte depth.
// RULE5: key A4h closes the extended page; format 03h gives 8N1.
// RULE6: interrupt enable 03h enables receive and transmit interrupts.
// RULE7: status id 04h means receive, 02h means transmit.
// RULE8: modem control bit 6 swaps count registers in for normal ones.
// RULE9: transmit count reads free room the host may fill next.
// RULE10: receive count reads bytes held in the receive fifo.
// RULE11: status bit 7 flags empty 256-byte transmit fifo; host writes 128.
// RULE12: otherwise host writes 128 or the count read, whichever smaller.
// RULE13: each transmit holding write pushes one byte for serial output.
// RULE14: status bit 6 flags full receive fifo; host reads 256 bytes.
// RULE15: each receive buffer read pops and returns one byte.
// RULE16: receive interrupt at fill >= trigger; transmit at fill <= trigger. Code: a receive trigger of 00h never interrupts.
// RULE17: status read reports highest pending source, fifos untouched.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module ufc_channel import ufc_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire  logic              aclk,
    input  wire  logic              aresetn,
    // write address and data
    input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire  logic              s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire  logic [31:0]       s_axi_wdata,
    input  wire  logic [3:0]        s_axi_wstrb,
    input  wire  logic              s_axi_wvalid,
    output logic                    s_axi_wready,
    // write response
    output logic       [1:0]        s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire  logic              s_axi_bready,
    // read address and data
    input  wire  logic [ADDR_W-1:0] s_axi_araddr,
    input  wire  logic              s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic       [31:0]       s_axi_rdata,
    output logic       [1:0]        s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire  logic              s_axi_rready,
    // serial pins and interrupt
    output logic                    txd,
    input  wire  logic              rxd,
    output logic                    irq
);
    logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
    logic        awok_q, awok_d, wok_q, wok_d, awbad_q, awbad_d, wstb_q, wstb_d;
    logic        bvalid_q, bvalid_d, rpend_q, rpend_d, arbad_q, arbad_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [3:0]  awidx_q, awidx_d, aridx_q, aridx_d;
    logic [7:0]  wdat_q, wdat_d;
    logic [31:0] rdata_q, rdata_d, rd_word;
    logic [7:0]  lfc_q, lfc_d, ier_q, ier_d, mcr_q, mcr_d, dll_q, dll_d;
    logic [7:0]  dlh_q, dlh_d, ttr_q, ttr_d, rtr_q, rtr_d, afr_q, afr_d;
    logic [7:0]  key_q, key_d;
    logic [3:0]  ev_st_q, ev_st_d, ev_en_q, ev_en_d, ev_clr, ev_set;
    logic        irq_q, irq_d, rxp_q, txp_q;
    logic [15:0] bcnt_q, bcnt_d, div;
    logic        tick;
    logic        div_acc, ext_pg, ext_open, cnt_acc, big;
    logic        tx_push, rx_pop, tx_take, tx_idle, rx_stb, rx_err;
    logic        rx_pend, tx_pend, rx_int, tx_int;
    logic [7:0]  rx_byte, interrupt_source_status;
    logic [8:0]  cap, tx_room;
    logic [1:0]  push, pop, full, avail;
    logic [1:0][7:0] wp_q, rp_q, fw_data, fr_data;
    logic [1:0][8:0] cnt_q;
    logic [1:0]      fresh_q;

    function automatic logic bad_addr(input logic [ADDR_W-1:0] a);
        return (|a[ADDR_W-1:6]) || (a[5:2] > IDX_EV_EN);
    endfunction

    assign div_acc  = lfc_q[LFC_DIV_BIT] && lfc_q != LFC_EXT; // RULE1
    assign ext_pg   = (lfc_q == LFC_EXT);
    assign ext_open = ext_pg && key_q == KEY_OPEN; // RULE3 RULE5
    assign cnt_acc  = mcr_q[MCR_CNT_BIT] && !lfc_q[LFC_DIV_BIT]; // RULE8
    assign big      = afr_q[AFR_BIG_BIT];
    assign cap      = big ? 9'(DEPTH_BIG) : 9'(DEPTH_SMALL); // RULE4
    assign tx_room  = cap - cnt_q[0];

    // fifo 0 carries transmit bytes, fifo 1 receive bytes
    assign push       = {rx_stb && !full[1], tx_push};
    assign pop        = {rx_pop, tx_take};
    assign fw_data[0] = wdat_q;
    assign fw_data[1] = rx_byte;

    for (genvar g = 0; g < 2; g++) begin : g_fifo
        logic [7:0] wp_d, rp_d;
        logic [8:0] cnt_d;
        logic       fresh_d;

        // a byte just written into an empty fifo is not yet on the read port
        assign full[g]  = (cnt_q[g] >= cap);
        assign avail[g] = (cnt_q[g] != 9'd0) && !fresh_q[g];

        ufc_fifo_mem #(.W(8), .DEPTH(DEPTH_BIG), .AW(8)) u_mem (
            .aclk    (aclk),
            .wr_en   (push[g]),
            .wr_addr (wp_q[g]),
            .wr_data (fw_data[g]),
            .rd_addr (rp_q[g]),
            .rd_data (fr_data[g])
        );

        always_comb begin
            wp_d    = wp_q[g] + 8'(push[g]);
            rp_d    = rp_q[g] + 8'(pop[g]);
            cnt_d   = cnt_q[g] + 9'(push[g]) - 9'(pop[g]);
            fresh_d = push[g] && cnt_q[g] == 9'd0;
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                wp_q[g] <= 8'h00; rp_q[g] <= 8'h00; cnt_q[g] <= 9'd0; fresh_q[g] <= 1'b0;
            end else begin
                wp_q[g] <= wp_d; rp_q[g] <= rp_d; cnt_q[g] <= cnt_d; fresh_q[g] <= fresh_d;
            end
        end
    end

    // baud enable at sixteen times the bit rate; divisor zero acts as one
    assign div  = {dlh_q, dll_q};
    assign tick = (bcnt_q + 16'h0001 >= div);

    always_comb begin
        bcnt_d = tick ? 16'h0000 : bcnt_q + 16'h0001;
    end

    ufc_serial u_serial (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick     (tick),
        .dbits    (lfc_q[1:0]), // RULE5
        .two_stop (lfc_q[2]),
        .par_en   (lfc_q[3]),
        .par_even (lfc_q[4]),
        .tx_valid (avail[0]),
        .tx_byte  (fr_data[0]),
        .tx_take  (tx_take),
        .tx_idle  (tx_idle),
        .rx_stb   (rx_stb),
        .rx_byte  (rx_byte),
        .rx_err   (rx_err),
        .txd      (txd),
        .rxd      (rxd)
    );

    // interrupt sources
    assign rx_pend = (rtr_q != 8'h00) && (cnt_q[1] >= {1'b0, rtr_q}); // RULE16
    assign tx_pend = (cnt_q[0] <= {1'b0, ttr_q}); // RULE16
    assign rx_int  = rx_pend && ier_q[IER_RX_BIT]; // RULE6
    assign tx_int  = tx_pend && ier_q[IER_TX_BIT]; // RULE6
    // receive outranks transmit; reading this has no side effect
    assign interrupt_source_status = {big && cnt_q[0] == 9'd0, // RULE11
                  big && cnt_q[1] == 9'(DEPTH_BIG), // RULE14
                  rx_int ? ISR_ID_RX : tx_int ? ISR_ID_TX : ISR_ID_NONE}; // RULE7 RULE17
    assign ev_set = {rx_stb && rx_err, rx_stb && full[1], tx_pend && !txp_q, rx_pend && !rxp_q};

    always_comb begin
        ev_st_d = (ev_st_q & ~ev_clr) | ev_set; // set beats a same-cycle clear
        irq_d   = (|(ev_st_q & ev_en_q)) || rx_int || tx_int;
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (aridx_q)
            IDX_DATA: rd_word[7:0] = div_acc ? dll_q : ext_pg ? 8'h00 : fr_data[1]; // RULE15
            IDX_IER:  rd_word[7:0] = div_acc ? dlh_q : ier_q;
            IDX_ISR:  rd_word[7:0] = interrupt_source_status; // RULE17
            IDX_LFC:  rd_word[7:0] = lfc_q;
            IDX_MCR:  rd_word[7:0] = ext_pg ? ttr_q : mcr_q;
            IDX_LSR: begin
                if (ext_pg) rd_word[7:0] = rtr_q;
                else if (cnt_acc) rd_word[8:0] = tx_room; // RULE9
                else rd_word[7:0] = {1'b0, tx_idle && cnt_q[0] == 9'd0,
                                     cnt_q[0] == 9'd0, 4'h0, avail[1]};
            end
            IDX_AUX: begin
                if (ext_pg) rd_word[7:0] = afr_q;
                else if (cnt_acc) rd_word[8:0] = cnt_q[1]; // RULE10
            end
            IDX_KEY:   rd_word[7:0] = ext_pg ? key_q : 8'h00;
            IDX_EV_ST: rd_word[3:0] = ev_st_q;
            IDX_EV_EN: rd_word[3:0] = ev_en_q;
            default:   rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        awok_d = awok_q; wok_d = wok_q; awidx_d = awidx_q; awbad_d = awbad_q;
        wdat_d = wdat_q; wstb_d = wstb_q; bvalid_d = bvalid_q; bresp_d = bresp_q;
        rpend_d = rpend_q; aridx_d = aridx_q; arbad_d = arbad_q;
        rvalid_d = rvalid_q; rresp_d = rresp_q; rdata_d = rdata_q;
        lfc_d = lfc_q; ier_d = ier_q; mcr_d = mcr_q; dll_d = dll_q; dlh_d = dlh_q;
        ttr_d = ttr_q; rtr_d = rtr_q; afr_d = afr_q; key_d = key_q; ev_en_d = ev_en_q;
        ev_clr = 4'h0; tx_push = 1'b0; rx_pop = 1'b0;
        if (s_axi_awvalid && awrdy_q) begin
            awok_d = 1'b1; awidx_d = s_axi_awaddr[5:2]; awbad_d = bad_addr(s_axi_awaddr);
        end
        if (s_axi_wvalid && wrdy_q) begin
            wok_d = 1'b1; wdat_d = s_axi_wdata[7:0]; wstb_d = s_axi_wstrb[0];
        end
        if (awok_q && wok_q) begin
            awok_d = 1'b0; wok_d = 1'b0; bvalid_d = 1'b1;
            bresp_d = awbad_q ? RESP_SLVERR : RESP_OKAY;
            if (!awbad_q && wstb_q) begin
                case (awidx_q)
                    IDX_DATA: begin
                        if (div_acc) dll_d = wdat_q; // RULE1
                        else if (!ext_pg) tx_push = !full[0]; // RULE13
                    end
                    IDX_IER: begin
                        if (div_acc) dlh_d = wdat_q; // RULE1
                        else if (!ext_pg) ier_d = wdat_q; // RULE6
                    end
                    IDX_LFC: lfc_d = wdat_q;
                    IDX_MCR: begin
                        if (!ext_pg) mcr_d = wdat_q; // RULE8
                        else if (ext_open) ttr_d = wdat_q; // RULE3
                    end
                    IDX_RTR: if (ext_open) rtr_d = wdat_q; // RULE3
                    IDX_AFR: if (ext_open) afr_d = wdat_q; // RULE3 RULE4
                    IDX_KEY: if (ext_pg) key_d = wdat_q; // RULE5
                    IDX_EV_CLR: ev_clr = wdat_q[3:0];
                    IDX_EV_EN:  ev_en_d = wdat_q[3:0];
                    default: ;
                endcase
            end
        end
        if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
        if (s_axi_arvalid && arrdy_q) begin
            rpend_d = 1'b1; aridx_d = s_axi_araddr[5:2]; arbad_d = bad_addr(s_axi_araddr);
        end
        if (rpend_q) begin
            rpend_d  = 1'b0;
            rvalid_d = 1'b1;
            rresp_d  = arbad_q ? RESP_SLVERR : RESP_OKAY;
            rdata_d  = arbad_q ? 32'h0000_0000 : rd_word;
            if (!arbad_q && aridx_q == IDX_DATA && !div_acc && !ext_pg)
                rx_pop = avail[1]; // RULE15
        end
        if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
        awrdy_d = !awok_d && !bvalid_d;
        wrdy_d  = !wok_d && !bvalid_d;
        arrdy_d = !rpend_d && !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awrdy_q <= 1'b0; wrdy_q <= 1'b0; arrdy_q <= 1'b0;
            awok_q <= 1'b0; wok_q <= 1'b0; awbad_q <= 1'b0; wstb_q <= 1'b0;
            awidx_q <= 4'h0; wdat_q <= 8'h00; bvalid_q <= 1'b0; bresp_q <= RESP_OKAY;
            rpend_q <= 1'b0; aridx_q <= 4'h0; arbad_q <= 1'b0;
            rvalid_q <= 1'b0; rresp_q <= RESP_OKAY; rdata_q <= 32'h0000_0000;
            lfc_q <= LFC_RST; ier_q <= IER_RST; mcr_q <= MCR_RST;
            dll_q <= DIV_RST[7:0]; dlh_q <= DIV_RST[15:8];
            ttr_q <= TTR_RST; rtr_q <= RTR_RST; afr_q <= AFR_RST; key_q <= KEY_RST;
            ev_st_q <= 4'h0; ev_en_q <= 4'h0; irq_q <= 1'b0;
            rxp_q <= 1'b0; txp_q <= 1'b0; bcnt_q <= 16'h0000;
        end else begin
            awrdy_q <= awrdy_d; wrdy_q <= wrdy_d; arrdy_q <= arrdy_d;
            awok_q <= awok_d; wok_q <= wok_d; awbad_q <= awbad_d; wstb_q <= wstb_d;
            awidx_q <= awidx_d; wdat_q <= wdat_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d;
            rpend_q <= rpend_d; aridx_q <= aridx_d; arbad_q <= arbad_d;
            rvalid_q <= rvalid_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
            lfc_q <= lfc_d; ier_q <= ier_d; mcr_q <= mcr_d; dll_q <= dll_d; dlh_q <= dlh_d;
            ttr_q <= ttr_d; rtr_q <= rtr_d; afr_q <= afr_d; key_q <= key_d;
            ev_st_q <= ev_st_d; ev_en_q <= ev_en_d; irq_q <= irq_d;
            rxp_q <= rx_pend; txp_q <= tx_pend; bcnt_q <= bcnt_d;
        end
    end

    assign s_axi_awready = awrdy_q;
    assign s_axi_wready  = wrdy_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arrdy_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign irq           = irq_q;
endmodule

// ---- tb/ufc_channel_props.sv ----
// port checks for the serial channel
`timescale 1ns/100ps
module ufc_channel_props (
    // ports packed to stay short
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic        txd, irq,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_rh; s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rh: assert property (p_rh) else $error("read answer moved");
    property p_awb; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_awb: assert property (p_awb) else $error("write taken early");
    property p_arb; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arb: assert property (p_arb) else $error("read taken early");
    property p_bl; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid; endproperty
    a_bl: assert property (p_bl) else $error("no write answer");
    property p_rl; s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid; endproperty
    a_rl: assert property (p_rl) else $error("no read answer");
    property p_rdy; $fell(s_axi_bvalid) |-> ##[0:2] s_axi_awready; endproperty
    a_rdy: assert property (p_rdy) else $error("write not reopened");
    // divisor one: sixteen clocks a bit
    property p_st; $fell(txd) |-> (!txd) [*8]; endproperty
    a_st: assert property (p_st) else $error("start bit short");
    c_w: cover property (s_axi_bvalid && s_axi_bready);
    c_r: cover property (s_axi_rvalid && s_axi_rready);
    c_i: cover property ($rose(irq));
endmodule
bind ufc_channel ufc_channel_props u_props (.*);

// ---- tb/ufc_remote.sv ----
// remote serial end: sends on rxd, collects from txd
`timescale 1ns/100ps
module ufc_remote (
    input  wire logic aclk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got[$];
    logic [7:0] b;
    initial rxd = '1;
    // 8N1 at sixteen clocks a bit
    task automatic send(input logic [7:0] d);
        rxd <= '0;
        repeat (16) @(posedge aclk);
        for (int k = 0; k < 9; k++) begin
            rxd <= (k < 8) ? d[k] : 1'b1;
            repeat (16) @(posedge aclk);
        end
    endtask
    always begin
        @(negedge txd);
        repeat (8) @(posedge aclk);
        for (int k = 0; k < 8; k++) begin
            repeat (16) @(posedge aclk);
            b[k] = txd;
        end
        got.push_back(b);
    end
endmodule

// ---- tb/ufc_channel_tb.sv ----
// channel bench: bus tasks, register table, serial traffic
`timescale 1ns/100ps
module ufc_channel_tb import ufc_pkg::*;;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, rxd, txd, irq, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int failures = 0, checked = 0;
    // {index, write, expected read}; index 0 is not read back
    logic [19:0] rows [15] = '{20'h3_8080, 20'h0_0100, 20'h1_0000, 20'h3_0000, 20'h3_bfbf,
        20'h4_3008, 20'h7_a5a5, 20'h4_2020, 20'h5_8080, 20'h6_0101, 20'h7_a4a4, 20'h4_3020,
        20'h3_0303, 20'h1_0303, 20'h4_0000};
    always #2.5 aclk = ~aclk;
    ufc_channel DUT (.*);
    ufc_remote RM (.*);
    task automatic chk(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        s_axi_bready <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), (i > 4'ha) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
        s_axi_bready <= '0;
    endtask
    task automatic rc(input logic [3:0] i, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), (i > 4'ha) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
        s_axi_rready <= '0;
    endtask
    task automatic summarize;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        summarize;
    end
    initial begin
        repeat (20) @(posedge aclk);
        chk(32'(irq), 0);
        chk(32'(txd), 1);
        aresetn <= '1;
        rc(3, 0);
        rc(4'hb, 0);
        wr(4'hb, 8'h00);
        rc(8, 32'h2);
        wr(10, 8'h02);
        rc(8, 32'h2);
        chk(32'(irq), 1);
        wr(9, 8'h02);
        rc(8, 0);
        chk(32'(irq), 0);
        wr(10, 8'h00);
        foreach (rows[n]) begin
            wr(rows[n][19:16], rows[n][15:8]);
            if (rows[n][19:16] != 0) rc(rows[n][19:16], 32'(rows[n][7:0]));
        end
        rc(2, 32'h82);
        chk(32'(irq), 1);
        wr(4, 8'h40);
        rc(5, 32'h100);
        rc(6, 0);
        wr(4, 8'h00);
        rc(5, 32'h60);
        for (int k = 0; k < 3; k++) wr(0, 8'h5a + 8'(k));
        for (int k = 0; k < 2000 && RM.got.size() < 3; k++) @(posedge aclk);
        for (int k = 0; k < 3; k++) chk(32'(RM.got[k]), 32'h5a + k);
        for (int k = 0; k < 256; k++) RM.send(8'(k));
        rc(2, 32'hc4);
        wr(4, 8'h40);
        rc(6, 32'h100);
        wr(4, 8'h00);
        for (int k = 0; k < 256; k++) rc(0, 32'(k));
        rc(2, 32'h82);
        aresetn <= '0;
        repeat (2) @(posedge aclk);
        aresetn <= '1;
        rc(3, 0);
        rc(8, 32'h2);
        summarize;
    end
endmodule
